// file: inc/pll_ctrl_pkg.sv
// Constants shared by the PLL mode control register block.
package pll_ctrl_pkg;

  // ==========================================================================
  // Bus addressing
  localparam logic [4:0] DEV_ADDR_BASE = 5'h1a;
  localparam logic [7:0] PLL_MODE_CONTROL_OFS = 8'h00;
  localparam logic [7:0] BANDWIDTH_AND_RATE_OFS = 8'h02;
  localparam logic [7:0] FREEZE_AND_CAL_SQUELCH_OFS = 8'h03;

  // ==========================================================================
  // Field positions
  localparam int FREE_RUN_BIT = 6;
  localparam int UNSQUELCH_BIT = 5;
  localparam int BYPASS_BIT = 1;
  localparam int BW_MSB = 7;
  localparam int BW_LSB = 4;
  localparam int RATE_MSB = 3;
  localparam int RATE_LSB = 0;
  localparam int HOLD_FORCE_BIT = 5;
  localparam int MUTE_CAL_BIT = 4;

  // ==========================================================================
  // Reset values and writable masks
  localparam logic [7:0] PLL_MODE_CONTROL_RST = 8'h14;
  localparam logic [7:0] BANDWIDTH_AND_RATE_RST = 8'h42;
  localparam logic [7:0] FREEZE_AND_CAL_SQUELCH_RST = 8'h05;
  localparam logic [7:0] PLL_MODE_CONTROL_WMASK = 8'h62;
  localparam logic [7:0] BANDWIDTH_AND_RATE_WMASK = 8'hff;
  localparam logic [7:0] FREEZE_AND_CAL_SQUELCH_WMASK = 8'h30;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================================
  // Oscillator rate codes
  localparam logic [3:0] RATE_CODE_LOW = 4'h5;
  localparam logic [3:0] RATE_CODE_HIGH = 4'h6;

  // Calibration tracking states.
  typedef enum logic [2:0] {
    CAL_NONE = 3'b001,
    CAL_RUN = 3'b010,
    CAL_OK = 3'b100
  } cal_state_t;

endpackage : pll_ctrl_pkg

// file: rtl/pll_mode_control_regs.sv
// Mode control registers 0, 2 and 3 of one synthesis PLL.
`timescale 1ns/1ps

module pll_mode_control_regs
  import pll_ctrl_pkg::*;
#(
  parameter logic [1:0] PLL_INDEX = 2'b00
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [6:0] bus_dev_addr,
  input wire logic [7:0] bus_reg_addr,
  input wire logic bus_wr_en,
  input wire logic [7:0] bus_wr_data,
  input wire logic bus_rd_en,
  output logic [7:0] bus_rd_data,
  output logic bus_rd_valid,
  output logic bus_selected,
  input wire logic self_calibration_start,
  input wire logic self_calibration_done,
  output logic free_run_enable,
  output logic bypass_enable,
  output logic output_unsquelch_override,
  output logic [3:0] loop_bandwidth_code,
  output logic [3:0] applied_bandwidth_code,
  output logic [3:0] osc_rate_code,
  output logic oscillator_hold_force,
  output logic mute_during_calibration,
  output logic self_calibration_busy,
  output logic self_calibration_complete,
  output logic clock_output_enable
);

  // ==========================================================================
  // Register storage
  logic [7:0] pll_mode_control_reg;
  logic [7:0] bandwidth_and_rate_reg;
  logic [7:0] freeze_and_cal_squelch_reg;
  logic [3:0] applied_bw_reg;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  cal_state_t cal_state_reg;
  cal_state_t cal_state_next;
  logic wr_hit;
  logic rd_hit;

  // Merges writable bits into a register, leaving read-only bits untouched.
  function automatic logic [7:0] merge_write(input logic [7:0] old_val,
                                             input logic [7:0] new_val,
                                             input logic [7:0] mask);
    merge_write = (old_val & ~mask) | (new_val & mask);
  endfunction : merge_write

  // ==========================================================================
  // Address decode
  assign bus_selected = (bus_dev_addr == {DEV_ADDR_BASE, PLL_INDEX});
  assign wr_hit = bus_selected & bus_wr_en;
  assign rd_hit = bus_selected & bus_rd_en;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pll_mode_control_reg <= PLL_MODE_CONTROL_RST;
    end else if (wr_hit && bus_reg_addr == PLL_MODE_CONTROL_OFS) begin
      pll_mode_control_reg <= merge_write(pll_mode_control_reg, bus_wr_data,
                                          PLL_MODE_CONTROL_WMASK);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bandwidth_and_rate_reg <= BANDWIDTH_AND_RATE_RST;
    end else if (wr_hit && bus_reg_addr == BANDWIDTH_AND_RATE_OFS) begin
      // Reserved rate codes are stored as written; the host picks the range.
      bandwidth_and_rate_reg <= merge_write(bandwidth_and_rate_reg, bus_wr_data,
                                            BANDWIDTH_AND_RATE_WMASK);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      freeze_and_cal_squelch_reg <= FREEZE_AND_CAL_SQUELCH_RST;
    end else if (wr_hit && bus_reg_addr == FREEZE_AND_CAL_SQUELCH_OFS) begin
      freeze_and_cal_squelch_reg <= merge_write(freeze_and_cal_squelch_reg,
                                                bus_wr_data,
                                                FREEZE_AND_CAL_SQUELCH_WMASK);
    end
  end

  // ==========================================================================
  // Read path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_reg <= UNMAPPED_READ;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_hit;
      if (rd_hit) begin
        unique case (bus_reg_addr)
          PLL_MODE_CONTROL_OFS: rd_data_reg <= pll_mode_control_reg;
          BANDWIDTH_AND_RATE_OFS: rd_data_reg <= bandwidth_and_rate_reg;
          FREEZE_AND_CAL_SQUELCH_OFS: rd_data_reg <= freeze_and_cal_squelch_reg;
          default: rd_data_reg <= UNMAPPED_READ;
        endcase
      end
    end
  end

  assign bus_rd_data = rd_data_reg;
  assign bus_rd_valid = rd_valid_reg;

  // ==========================================================================
  // Calibration tracking
  always_comb begin
    cal_state_next = cal_state_reg;
    unique case (cal_state_reg)
      CAL_NONE: begin
        if (self_calibration_start) begin
          cal_state_next = CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (self_calibration_done) begin
          cal_state_next = CAL_OK;
        end
      end
      CAL_OK: begin
        if (self_calibration_start) begin
          cal_state_next = CAL_RUN;
        end
      end
      default: cal_state_next = CAL_NONE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_state_reg <= CAL_NONE;
    end else begin
      cal_state_reg <= cal_state_next;
    end
  end

  // The loop keeps its old bandwidth until a calibration is started, so a
  // half-written setting never disturbs a locked loop.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      applied_bw_reg <= BANDWIDTH_AND_RATE_RST[BW_MSB:BW_LSB];
    end else if (self_calibration_start) begin
      applied_bw_reg <= bandwidth_and_rate_reg[BW_MSB:BW_LSB];
    end
  end

  // ==========================================================================
  // Control outputs
  assign free_run_enable = pll_mode_control_reg[FREE_RUN_BIT];
  assign output_unsquelch_override = pll_mode_control_reg[UNSQUELCH_BIT];
  // Bypass legality depends on hold state and output format, which the host owns.
  assign bypass_enable = pll_mode_control_reg[BYPASS_BIT];
  assign loop_bandwidth_code = bandwidth_and_rate_reg[BW_MSB:BW_LSB];
  assign applied_bandwidth_code = applied_bw_reg;
  assign osc_rate_code = bandwidth_and_rate_reg[RATE_MSB:RATE_LSB];
  assign oscillator_hold_force = freeze_and_cal_squelch_reg[HOLD_FORCE_BIT];
  assign mute_during_calibration = freeze_and_cal_squelch_reg[MUTE_CAL_BIT];
  assign self_calibration_busy = (cal_state_reg == CAL_RUN);
  assign self_calibration_complete = (cal_state_reg == CAL_OK);

  // Before the first calibration the output is also held while muting is on.
  assign clock_output_enable = output_unsquelch_override
                             | self_calibration_complete
                             | ~mute_during_calibration;

  // ==========================================================================
  // Checks
  a_reg0_reset_value: assert property (@(posedge clk)
    $rose(arst_n) |-> pll_mode_control_reg == 8'h14)
    else $error("Register 0 not at reset value after release.");

  a_reg2_reset_value: assert property (@(posedge clk)
    $rose(arst_n) |-> bandwidth_and_rate_reg == 8'h42)
    else $error("Register 2 not at reset value after release.");

  a_reg3_reset_value: assert property (@(posedge clk)
    $rose(arst_n) |-> freeze_and_cal_squelch_reg == 8'h05)
    else $error("Register 3 not at reset value after release.");

  a_free_run_write: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_hit && bus_reg_addr == 8'h00) |=> free_run_enable == $past(bus_wr_data[6]))
    else $error("Free-run enable does not follow written bit.");

  a_bypass_write: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_hit && bus_reg_addr == 8'h00) |=> bypass_enable == $past(bus_wr_data[1]))
    else $error("Bypass enable does not follow written bit.");

  a_hold_force_write: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_hit && bus_reg_addr == 8'h03)
      |=> oscillator_hold_force == $past(bus_wr_data[5]))
    else $error("Hold force does not follow written bit.");

  a_bw_waits_cal: assert property (@(posedge clk) disable iff (!arst_n)
    !self_calibration_start |=> $stable(applied_bandwidth_code))
    else $error("Applied bandwidth changed without calibration.");

  a_bw_applied_at_cal: assert property (@(posedge clk) disable iff (!arst_n)
    self_calibration_start |=> applied_bandwidth_code == $past(bandwidth_and_rate_reg[7:4]))
    else $error("Bandwidth not applied at calibration start.");

  a_mute_during_cal: assert property (@(posedge clk) disable iff (!arst_n)
    (self_calibration_busy && mute_during_calibration && !output_unsquelch_override)
      |-> !clock_output_enable)
    else $error("Output enabled during muted calibration.");

  a_always_on_wins: assert property (@(posedge clk) disable iff (!arst_n)
    output_unsquelch_override |-> clock_output_enable)
    else $error("Output off although always-on is set.");

  a_unmuted_on: assert property (@(posedge clk) disable iff (!arst_n)
    (self_calibration_complete || !mute_during_calibration) |-> clock_output_enable)
    else $error("Output off although calibrated or unmuted.");

  a_addr_match: assert property (@(posedge clk) disable iff (!arst_n)
    (bus_wr_en && bus_dev_addr != {DEV_ADDR_BASE, PLL_INDEX})
      |=> $stable(pll_mode_control_reg) && $stable(bandwidth_and_rate_reg)
          && $stable(freeze_and_cal_squelch_reg))
    else $error("Write to foreign address changed registers.");

  // ==========================================================================
  // Bus and calibration checks
  // Read-only bits must keep their reset values whatever the host writes.
  a_reg0_fixed_bits: assert property (@(posedge clk) disable iff (!arst_n)
    (pll_mode_control_reg & ~PLL_MODE_CONTROL_WMASK)
      == (PLL_MODE_CONTROL_RST & ~PLL_MODE_CONTROL_WMASK))
    else $error("Register 0 read-only bits changed.");

  a_reg3_fixed_bits: assert property (@(posedge clk) disable iff (!arst_n)
    (freeze_and_cal_squelch_reg & ~FREEZE_AND_CAL_SQUELCH_WMASK)
      == (FREEZE_AND_CAL_SQUELCH_RST & ~FREEZE_AND_CAL_SQUELCH_WMASK))
    else $error("Register 3 read-only bits changed.");

  a_override_write: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_hit && bus_reg_addr == PLL_MODE_CONTROL_OFS)
      |=> output_unsquelch_override == $past(bus_wr_data[UNSQUELCH_BIT]))
    else $error("Always-on bit does not follow written bit.");

  a_mute_write: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_hit && bus_reg_addr == FREEZE_AND_CAL_SQUELCH_OFS)
      |=> mute_during_calibration == $past(bus_wr_data[MUTE_CAL_BIT]))
    else $error("Mute bit does not follow written bit.");

  a_reg2_write: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_hit && bus_reg_addr == BANDWIDTH_AND_RATE_OFS)
      |=> {loop_bandwidth_code, osc_rate_code} == $past(bus_wr_data))
    else $error("Register 2 does not hold the written byte.");

  a_rd_valid_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    rd_hit |=> bus_rd_valid)
    else $error("Addressed read gave no valid pulse.");

  a_no_stray_valid: assert property (@(posedge clk) disable iff (!arst_n)
    !rd_hit |=> !bus_rd_valid)
    else $error("Valid pulse without addressed read.");

  a_reg0_read: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_hit && bus_reg_addr == PLL_MODE_CONTROL_OFS)
      |=> bus_rd_data == $past(pll_mode_control_reg))
    else $error("Register 0 read returned wrong data.");

  a_reg3_read: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_hit && bus_reg_addr == FREEZE_AND_CAL_SQUELCH_OFS)
      |=> bus_rd_data == $past(freeze_and_cal_squelch_reg))
    else $error("Register 3 read returned wrong data.");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_hit && bus_reg_addr != PLL_MODE_CONTROL_OFS && bus_reg_addr != BANDWIDTH_AND_RATE_OFS
      && bus_reg_addr != FREEZE_AND_CAL_SQUELCH_OFS) |=> bus_rd_data == UNMAPPED_READ)
    else $error("Unmapped read returned nonzero data.");

  a_cal_starts: assert property (@(posedge clk) disable iff (!arst_n)
    (self_calibration_start && !self_calibration_busy) |=> self_calibration_busy)
    else $error("Calibration start did not mark busy.");

  a_cal_completes: assert property (@(posedge clk) disable iff (!arst_n)
    (self_calibration_busy && self_calibration_done) |=> self_calibration_complete)
    else $error("Calibration done did not mark complete.");

  a_cal_idle_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (!self_calibration_busy && !self_calibration_start) |=> $stable(cal_state_reg))
    else $error("Calibration state moved without a start.");

  a_cal_state_legal: assert property (@(posedge clk) disable iff (!arst_n)
    $onehot(cal_state_reg))
    else $error("Calibration state is not one-hot.");

  // Muting also applies before the first calibration, not only while one runs.
  a_muted_before_cal: assert property (@(posedge clk) disable iff (!arst_n)
    (!self_calibration_complete && mute_during_calibration && !output_unsquelch_override)
      |-> !clock_output_enable)
    else $error("Output enabled before muted calibration completed.");

endmodule : pll_mode_control_regs

// file: sim/pll_host_model.sv
// Register bus host model that programs one PLL's control registers.
`timescale 1ns/1ps
module pll_host_model
  import pll_ctrl_pkg::*;
(
  input wire logic clk,
  output logic [6:0] dev_addr,
  output logic [7:0] reg_addr,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic rd_en
);
  initial begin
    dev_addr = 7'h00;
    reg_addr = 8'h00;
    wr_en = 1'b0;
    wr_data = 8'h00;
    rd_en = 1'b0;
  end

  // ==========================================================================
  // One byte transfer
  // The host never selects the CMOS output format, so bypass stays legal here.
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ra, input logic wr,
      input logic [7:0] d, input int gap);
    logic [7:0] dv;
    dv = d;
    if (wr && ra == BANDWIDTH_AND_RATE_OFS && d[3:0] != RATE_CODE_HIGH) begin
      dv[3:0] = RATE_CODE_LOW;
    end
    repeat (gap) @(posedge clk);
    @(posedge clk);
    dev_addr <= dev;
    reg_addr <= ra;
    wr_en <= wr;
    rd_en <= !wr;
    wr_data <= dv;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    // Released register address and data lines show the inverse so a stale value cannot pass for a live one; the device address is held.
    reg_addr <= ~ra;
    wr_data <= ~dv;
  endtask : xfer
endmodule : pll_host_model

// file: sim/test_pll_mode_control_regs.sv
// Self-checking testbench for the PLL mode control registers.
`timescale 1ns/1ps
module test_pll_mode_control_regs;
  import pll_ctrl_pkg::*;
  localparam logic [6:0] DEV = {DEV_ADDR_BASE, 2'b10};
  logic clk, arst_n, cal_start, cal_done;
  logic [6:0] dev_addr;
  logic [7:0] reg_addr, wr_data, rd_data;
  logic wr_en, rd_en, rd_valid, sel, fr, byp, ovr, hold, mute, busy, cmpl, oen;
  logic [3:0] bw, abw, rate;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int total_checks = 0;
  int seed = 32'hf08efdc1;
  logic [7:0] r;

  pll_host_model pll_host_model_i (.clk(clk), .dev_addr(dev_addr), .reg_addr(reg_addr),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));
  pll_mode_control_regs #(.PLL_INDEX(2'b10)) pll_mode_control_regs_i (.clk(clk),
    .arst_n(arst_n), .bus_dev_addr(dev_addr), .bus_reg_addr(reg_addr), .bus_wr_en(wr_en),
    .bus_wr_data(wr_data), .bus_rd_en(rd_en), .bus_rd_data(rd_data), .bus_rd_valid(rd_valid),
    .bus_selected(sel), .self_calibration_start(cal_start), .self_calibration_done(cal_done),
    .free_run_enable(fr), .bypass_enable(byp), .output_unsquelch_override(ovr),
    .loop_bandwidth_code(bw), .applied_bandwidth_code(abw), .osc_rate_code(rate),
    .oscillator_hold_force(hold), .mute_during_calibration(mute),
    .self_calibration_busy(busy), .self_calibration_complete(cmpl),
    .clock_output_enable(oen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // Checking
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // Every read result is matched against the oldest expectation.
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected read", 8'h00, 8'hff);
      end else begin
        chk("read data", exp_q.pop_front(), rd_data);
      end
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    pll_host_model_i.xfer(DEV, a, 1'b1, d, 0);
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    pll_host_model_i.xfer(DEV, a, 1'b0, 8'h00, $unsigned($random(seed)) % 3);
  endtask : rd

  task automatic pulse(input bit done);
    @(posedge clk);
    cal_start <= !done;
    cal_done <= done;
    @(posedge clk);
    cal_start <= 1'b0;
    cal_done <= 1'b0;
    @(negedge clk);
  endtask : pulse

  task automatic final_report;
    if (exp_q.size() != 0) n_fail++;
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    arst_n = 1'b0;
    cal_start = 1'b0;
    cal_done = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h00, 8'h14);
    rd(8'h02, 8'h42);
    rd(8'h03, 8'h05);
    rd(8'h01, UNMAPPED_READ);
    wr(8'h00, 8'hff);
    chk("free run", 8'h01, {7'h0, fr});
    chk("override", 8'h01, {7'h0, ovr});
    chk("bypass", 8'h01, {7'h0, byp});
    chk("selected", 8'h01, {7'h0, sel});
    rd(8'h00, 8'h76);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h14);
    wr(8'h03, 8'hff);
    chk("hold force", 8'h01, {7'h0, hold});
    chk("mute", 8'h01, {7'h0, mute});
    pll_host_model_i.xfer({DEV_ADDR_BASE, 2'b01}, 8'h03, 1'b1, 8'h00, 0);
    pll_host_model_i.xfer({DEV_ADDR_BASE, 2'b11}, 8'h03, 1'b0, 8'h00, 0);
    @(negedge clk);
    chk("foreign sel", 8'h00, {7'h0, sel});
    wr(8'h01, 8'hff);
    rd(8'h03, 8'h35);
    rd(8'h01, UNMAPPED_READ);
    wr(8'h02, 8'h95);
    chk("bandwidth", 8'h09, {4'h0, bw});
    chk("applied bw", 8'h04, {4'h0, abw});
    chk("rate", 8'h05, {4'h0, rate});
    chk("out en idle", 8'h00, {7'h0, oen});
    pulse(1'b0);
    chk("busy", 8'h01, {7'h0, busy});
    chk("applied new", 8'h09, {4'h0, abw});
    chk("out en cal", 8'h00, {7'h0, oen});
    pulse(1'b1);
    chk("complete", 8'h01, {7'h0, cmpl});
    chk("out en done", 8'h01, {7'h0, oen});
    wr(8'h00, 8'h20);
    pulse(1'b0);
    chk("out en always on", 8'h01, {7'h0, oen});
    wr(8'h00, 8'h00);
    chk("out en muted", 8'h00, {7'h0, oen});
    wr(8'h03, 8'h00);
    chk("hold off", 8'h00, {7'h0, hold});
    chk("out en unmuted", 8'h01, {7'h0, oen});
    pulse(1'b1);
    chk("complete again", 8'h01, {7'h0, cmpl});
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      r[3:0] = (r[0]) ? RATE_CODE_HIGH : RATE_CODE_LOW;
      wr(8'h02, r);
      rd(8'h02, r);
    end
    @(negedge clk);
    chk("applied held", 8'h09, {4'h0, abw});
    // A reset in mid-run must bring every field back, whatever was written.
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("applied reset", 8'h04, {4'h0, abw});
    chk("cal reset", 8'h00, {6'h0, busy, cmpl});
    chk("out en reset", 8'h01, {7'h0, oen});
    rd(8'h00, 8'h14);
    rd(8'h02, 8'h42);
    rd(8'h03, 8'h05);
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : test_pll_mode_control_regs
